// ==== rtl/lmss_top.v ====
// Purpose: supervisor of special modes and safety monitors of a lift controller
// Assumes: pin inputs asynchronous, mode inputs active when de-energised
// Notes: drive, door and call handling act on the registered command outputs
`timescale 1ns/1ps
`include "lmss_consts.vh"

// Behaviour
// - Inspection blocks calls, doors, relevel, homing, emergency
// - Inspection slows at correction, stops terminal
// - Emergency operation blocks calls, doors; overtravel allowed
// - Both modes active stops and blocks travel; creep stays
// - Landing control off clears calls, blocks landing
// - Landing control off disables parking landing
// - Light failure stops at landing, faults, blocks
// - Hydraulic light failure lowers car home
// - Thermistor normal below 2.2k, trip above 2.7k
// - Overtemperature applies configured stop reaction
// - Overtemperature logged and reported at once
// - Hydraulic homing after idle, switch-off, light failure
// - Homing keeps creep; door cycles at bottom
// - Cabin light off after idle time
// - Top limit shuts down, returns, parks
// - Runtime trip shuts down, creep stays
// - Up-creep returns home; runtime trip blocks hard
// - Down-creep shuts down, creep stays
// - Overload sampled at standstill; creep kept
// - Excess pressure mode: off, lock, no lock
// - Magnet selector without pulses blocks travel
// - Encoder point missed in runtime blocks travel
module lmss_top #(
    parameter ADDR_W = 8,
    parameter [23:0] TICK_CYCLES = `LMSS_CLK_HZ * `LMSS_TICK_S
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite slave
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Mode inputs, active when de-energised
    input wire inspection_mode_input,
    input wire inspection_mode_input_alt,
    input wire emergency_operation_input,
    // Monitors
    input wire light_voltage_ok,
    input wire ptc_below_low,
    input wire ptc_above_high,
    input wire top_emergency_limit,
    input wire up_creep_fault,
    input wire down_creep_fault,
    input wire overload_input,
    input wire excess_pressure_input,
    input wire safety_circuit_closed,
    // Shaft and car state
    input wire shaft_pulse_input_a,
    input wire shaft_pulse_input_b,
    input wire encoder_point,
    input wire flush_level_switch,
    input wire correction_switch,
    input wire terminal_flush_level,
    input wire at_bottom_landing,
    input wire in_landing_zone,
    input wire car_moving,
    input wire door_closed,
    // Operator
    input wire call_end_button,
    input wire ok_button,
    // Call and door commands
    output reg calls_clear,
    output reg car_calls_block,
    output reg landing_calls_block,
    output reg door_open_inhibit,
    output reg door_cycle_req,
    output reg door_open_button_enable,
    output reg parking_disable,
    // Drive commands
    output reg speed_reduce,
    output reg terminal_stop,
    output reg terminal_overtravel_allow,
    output reg stop_immediate,
    output reg stop_next_flush,
    output reg motor_switch_off,
    output reg travel_block,
    output reg relevel_enable,
    output reg creep_enable,
    output reg homing_request,
    // Status
    output reg cabin_light_on,
    output reg fault_active,
    output reg remote_report,
    output reg runtime_blocked,
    output reg overload_active
);
    localparam ST_IDLE = 3'h0;
    localparam ST_SHUT = 3'h1;
    localparam ST_RETURN = 3'h2;
    localparam ST_PARK = 3'h3;
    localparam ST_BLOCK = 3'h4;
    localparam ST_DOWN = 3'h5;
    localparam [10:0] RT_MAX = `LMSS_RUNTIME_MAX_S;
    localparam [10:0] IDLE_MAX = `LMSS_IDLE_MAX_MIN * `LMSS_SEC_PER_MIN;

    function [10:0] light_secs;
        input [1:0] sel;
        begin
            case (sel)
                2'h1: light_secs = `LMSS_LIGHT_T1_MIN * `LMSS_SEC_PER_MIN;
                2'h2: light_secs = `LMSS_LIGHT_T2_MIN * `LMSS_SEC_PER_MIN;
                default: light_secs = `LMSS_LIGHT_T0_MIN * `LMSS_SEC_PER_MIN;
            endcase
        end
    endfunction

    // Synchronised pins
    wire [`LMSS_NIN-1:0] pins;
    wire [`LMSS_NIN-1:0] sp;
    assign pins = {inspection_mode_input, inspection_mode_input_alt,
        emergency_operation_input, light_voltage_ok, ptc_below_low, ptc_above_high,
        top_emergency_limit, up_creep_fault, down_creep_fault, overload_input,
        excess_pressure_input, safety_circuit_closed, shaft_pulse_input_a,
        shaft_pulse_input_b, encoder_point, flush_level_switch, correction_switch,
        terminal_flush_level, at_bottom_landing, in_landing_zone, car_moving,
        door_closed, call_end_button, ok_button};

    lmss_sync #(.W(`LMSS_NIN)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .din(pins),
        .dout(sp)
    );

    wire s_insp_n = sp[23] & sp[22];
    wire s_eeo_n = sp[21];
    wire s_light = sp[20];
    wire s_ptc_lo = sp[19];
    wire s_ptc_hi = sp[18];
    wire s_toplim = sp[17];
    wire s_upcr = sp[16];
    wire s_dncr = sp[15];
    wire s_ovl = sp[14];
    wire s_xp = sp[13];
    wire s_safe = sp[12];
    wire s_corr = sp[7];
    wire s_term = sp[6];
    wire s_bottom = sp[5];
    wire s_zone = sp[4];
    wire s_moving = sp[3];
    wire s_dclosed = sp[2];
    wire s_callend = sp[1];
    wire s_ok = sp[0];

    // Registers
    reg [7:0] ctrl;
    reg [5:0] rt_cfg;
    reg [9:0] idle_cfg;
    reg [1:0] light_sel;
    reg [6:0] flog;
    reg [23:0] prev;
    reg [2:0] state;
    reg up_src;
    reg ptc_trip;
    reg xp_locked;
    reg homing;
    reg light_off;
    reg [23:0] pre;
    reg [23:0] rt_pre;
    reg [10:0] rt_sec;
    reg [10:0] idle_sec;
    reg land_off_d;

    wire hyd = ctrl[`LMSS_CTRL_HYD];
    wire land_off = ctrl[`LMSS_CTRL_LAND_OFF];
    wire [1:0] xp_mode = ctrl[`LMSS_CTRL_XP_HI:`LMSS_CTRL_XP_LO];
    wire insp = ~s_insp_n;
    wire both = insp & ~s_eeo_n;
    wire eeo = ~s_eeo_n & ~insp;
    wire special = insp | ~s_eeo_n;
    wire light_fault = ~s_light;
    wire tick = (pre == TICK_CYCLES - 24'h000001);
    wire unblock = s_callend & s_ok & ~prev[0];
    wire pulse_edge = ctrl[`LMSS_CTRL_ENCODER] ? (sp[9] & ~prev[9]) :
        ((sp[11] ^ prev[11]) | (sp[10] ^ prev[10]));
    wire [10:0] rt_lim = ({5'h00, rt_cfg} > RT_MAX) ? RT_MAX : {5'h00, rt_cfg};
    wire [10:0] idle_lim = ({1'b0, idle_cfg} > IDLE_MAX) ? IDLE_MAX : {1'b0, idle_cfg};
    wire rt_trip = s_moving & (rt_sec >= rt_lim) & ~runtime_blocked;
    wire ptc_rise = s_ptc_hi & ~ptc_trip;
    wire idle = ~s_moving & s_dclosed;
    wire home_cond = hyd & ~special & ~s_bottom & ~s_moving &
        (ctrl[`LMSS_CTRL_SW_OFF] | light_fault | (idle & idle_sec >= idle_lim));
    wire xp_stop = (xp_mode == `LMSS_XP_NOLOCK & s_xp) | xp_locked;

    // AXI write channel, address and data taken in either order
    reg aw_held;
    reg w_held;
    reg [ADDR_W-1:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    wire aw_now = aw_held | s_axi_awvalid;
    wire w_now = w_held | s_axi_wvalid;
    wire [ADDR_W-1:0] wa = aw_held ? aw_addr : s_axi_awaddr;
    wire [31:0] wd = w_held ? w_data : s_axi_wdata;
    wire [3:0] ws = w_held ? w_strb : s_axi_wstrb;
    wire wr_go = aw_now & w_now & ~s_axi_bvalid;
    wire [7:0] wa8 = wa[7:0];
    wire [7:0] ra8 = s_axi_araddr[7:0];
    wire flog_wr = wr_go & (wa8 == `LMSS_REG_FLOG);

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= {ADDR_W{1'b0}};
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            ctrl <= `LMSS_CTRL_RST;
            rt_cfg <= RT_MAX[5:0];
            idle_cfg <= IDLE_MAX[9:0];
            light_sel <= `LMSS_LIGHT_RST;
        end else begin
            if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (wr_go) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= 2'h0;
                case (wa8)
                    `LMSS_REG_CTRL: ctrl <= ws[0] ? wd[7:0] : ctrl;
                    `LMSS_REG_RUNTIME: rt_cfg <= ws[0] ? wd[5:0] : rt_cfg;
                    `LMSS_REG_IDLE: idle_cfg <= {ws[1] ? wd[9:8] : idle_cfg[9:8],
                        ws[0] ? wd[7:0] : idle_cfg[7:0]};
                    `LMSS_REG_LIGHT: light_sel <= ws[0] ? wd[1:0] : light_sel;
                    `LMSS_REG_STATUS, `LMSS_REG_FLOG: s_axi_bresp <= 2'h0;
                    default: s_axi_bresp <= 2'h2;
                endcase
            end else begin
                if (s_axi_awvalid & s_axi_awready) begin
                    aw_held <= 1'b1;
                    aw_addr <= s_axi_awaddr;
                end
                if (s_axi_wvalid & s_axi_wready) begin
                    w_held <= 1'b1;
                    w_data <= s_axi_wdata;
                    w_strb <= s_axi_wstrb;
                end
            end
        end
    end

    // AXI read channel
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else if (s_axi_arvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            case (ra8)
                `LMSS_REG_CTRL: s_axi_rdata <= {24'h0, ctrl};
                `LMSS_REG_RUNTIME: s_axi_rdata <= {26'h0, rt_cfg};
                `LMSS_REG_IDLE: s_axi_rdata <= {22'h0, idle_cfg};
                `LMSS_REG_LIGHT: s_axi_rdata <= {30'h0, light_sel};
                `LMSS_REG_STATUS: s_axi_rdata <= {20'h0, state, runtime_blocked, ptc_trip,
                    xp_locked, homing, cabin_light_on, overload_active, both, eeo, insp};
                `LMSS_REG_FLOG: s_axi_rdata <= {25'h0, flog};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end
    end

    // Supervisor state
    reg [2:0] next_state;
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (hyd & s_toplim) begin
                    next_state = ST_SHUT;
                end else if (hyd & s_upcr) begin
                    next_state = ST_RETURN;
                end else if (hyd & s_dncr) begin
                    next_state = ST_DOWN;
                end
            end
            ST_SHUT: if (~s_toplim & s_safe) next_state = ST_RETURN;
            ST_RETURN: begin
                if (rt_trip & up_src & ~s_zone) begin
                    next_state = ST_BLOCK;
                end else if (s_bottom & ~s_moving) begin
                    next_state = ST_PARK;
                end
            end
            ST_PARK, ST_BLOCK, ST_DOWN: if (unblock) next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_IDLE;
            up_src <= 1'b0;
            prev <= 24'h0;
            ptc_trip <= 1'b0;
            xp_locked <= 1'b0;
            runtime_blocked <= 1'b0;
            homing <= 1'b0;
            light_off <= 1'b0;
            pre <= 24'h0;
            rt_pre <= 24'h0;
            rt_sec <= 11'h0;
            idle_sec <= 11'h0;
            flog <= 7'h00;
            land_off_d <= 1'b0;
            overload_active <= 1'b0;
        end else begin
            state <= next_state;
            if (state == ST_IDLE & next_state == ST_RETURN) up_src <= 1'b1;
            else if (state == ST_IDLE & next_state == ST_SHUT) up_src <= 1'b0;
            prev <= sp;
            land_off_d <= land_off;
            pre <= tick ? 24'h0 : pre + 24'h1;
            // Hysteresis between the two thresholds keeps the last verdict
            if (s_ptc_hi) ptc_trip <= 1'b1;
            else if (s_ptc_lo) ptc_trip <= 1'b0;
            if (xp_mode == `LMSS_XP_LOCK & s_xp) xp_locked <= 1'b1;
            else if (unblock | xp_mode != `LMSS_XP_LOCK) xp_locked <= 1'b0;
            if (rt_trip) runtime_blocked <= 1'b1;
            else if (unblock) runtime_blocked <= 1'b0;
            // Own prescaler, restarted per pulse
            if (~s_moving | pulse_edge) begin
                rt_pre <= 24'h0;
                rt_sec <= 11'h0;
            end else if (rt_pre == TICK_CYCLES - 24'h1) begin
                rt_pre <= 24'h0;
                rt_sec <= (rt_sec == 11'h7ff) ? rt_sec : rt_sec + 11'h1;
            end else begin
                rt_pre <= rt_pre + 24'h1;
            end
            if (~idle) idle_sec <= 11'h000;
            else if (tick & idle_sec != 11'h7ff) idle_sec <= idle_sec + 11'h001;
            if (~idle) light_off <= 1'b0;
            else if (idle_sec >= light_secs(light_sel)) light_off <= 1'b1;
            if (home_cond) homing <= 1'b1;
            else if (special | s_bottom) homing <= 1'b0;
            if (~s_moving) overload_active <= s_ovl;
            // Set wins over a clearing write
            flog <= (flog & ~(flog_wr ? wd[6:0] & {7{ws[0]}} : 7'h00)) |
                {s_xp & xp_mode != `LMSS_XP_OFF, s_dncr & hyd, s_upcr & hyd,
                s_toplim & hyd, rt_trip, light_fault, ptc_rise};
        end
    end

    // Registered command outputs
    wire hold_stop = (state == ST_SHUT) | (state == ST_BLOCK) | (state == ST_DOWN);
    wire ptc_alt = ctrl[`LMSS_CTRL_PTC_ALT];
    always @(posedge aclk) begin
        if (!aresetn) begin
            calls_clear <= 1'b0;
            car_calls_block <= 1'b0;
            landing_calls_block <= 1'b0;
            door_open_inhibit <= 1'b0;
            door_cycle_req <= 1'b0;
            door_open_button_enable <= 1'b0;
            parking_disable <= 1'b0;
            speed_reduce <= 1'b0;
            terminal_stop <= 1'b0;
            terminal_overtravel_allow <= 1'b0;
            stop_immediate <= 1'b0;
            stop_next_flush <= 1'b0;
            motor_switch_off <= 1'b0;
            travel_block <= 1'b0;
            relevel_enable <= 1'b0;
            creep_enable <= 1'b0;
            homing_request <= 1'b0;
            cabin_light_on <= 1'b1;
            fault_active <= 1'b0;
            remote_report <= 1'b0;
        end else begin
            calls_clear <= special | (land_off & ~land_off_d);
            car_calls_block <= special | (state != ST_IDLE);
            landing_calls_block <= special | land_off | (state != ST_IDLE);
            door_open_inhibit <= special;
            door_cycle_req <= (homing & s_bottom) |
                (state == ST_RETURN & next_state == ST_PARK);
            door_open_button_enable <= ~special;
            parking_disable <= land_off;
            speed_reduce <= special & s_corr;
            terminal_stop <= insp & s_term;
            terminal_overtravel_allow <= eeo;
            stop_immediate <= both | hold_stop | rt_trip | runtime_blocked | xp_stop |
                (ptc_trip & (hyd | ~ptc_alt));
            stop_next_flush <= (light_fault & ~special) |
                (ptc_trip & ~hyd & ptc_alt);
            motor_switch_off <= ptc_trip & ctrl[`LMSS_CTRL_PTC_SWOFF];
            travel_block <= both | runtime_blocked | hold_stop | (state == ST_PARK) |
                xp_stop | (light_fault & ~special & ~s_moving);
            relevel_enable <= ~special;
            // Creep stays live on hydraulic lifts except for the hard block after an up-creep return
            creep_enable <= hyd & (state != ST_BLOCK);
            homing_request <= ~special & ((homing & ~s_bottom) | (state == ST_RETURN) |
                (hyd & ptc_trip & ~ptc_alt));
            cabin_light_on <= ~light_off;
            fault_active <= light_fault | ptc_trip | runtime_blocked |
                (state != ST_IDLE);
            remote_report <= ptc_rise;
        end
    end
endmodule // lmss_top

// ==== include/lmss_consts.vh ====
// Purpose: constants of the lift mode safety supervisor
// Assumes: 10 MHz controller clock, AXI4-Lite register access
// Notes: times in seconds or minutes, cycles derived in code
`ifndef LMSS_CONSTS_VH
`define LMSS_CONSTS_VH

`define LMSS_CLK_HZ 10000000
`define LMSS_TICK_S 1
`define LMSS_SEC_PER_MIN 60

// Register byte offsets
`define LMSS_REG_CTRL 8'h00
`define LMSS_REG_RUNTIME 8'h04
`define LMSS_REG_IDLE 8'h08
`define LMSS_REG_LIGHT 8'h0c
`define LMSS_REG_STATUS 8'h10
`define LMSS_REG_FLOG 8'h14

// Control fields
`define LMSS_CTRL_HYD 0
`define LMSS_CTRL_LAND_OFF 1
`define LMSS_CTRL_SW_OFF 2
`define LMSS_CTRL_ENCODER 3
`define LMSS_CTRL_PTC_ALT 4
`define LMSS_CTRL_PTC_SWOFF 5
`define LMSS_CTRL_XP_LO 6
`define LMSS_CTRL_XP_HI 7
`define LMSS_CTRL_RST 8'h00

// Excess pressure modes
`define LMSS_XP_OFF 2'h0
`define LMSS_XP_LOCK 2'h1
`define LMSS_XP_NOLOCK 2'h2

// Timing limits and reset values
`define LMSS_RUNTIME_MAX_S 45
`define LMSS_IDLE_MAX_MIN 15
`define LMSS_LIGHT_T0_MIN 1
`define LMSS_LIGHT_T1_MIN 10
`define LMSS_LIGHT_T2_MIN 30
`define LMSS_LIGHT_RST 2'h0

`define LMSS_NIN 24

`endif

// ==== rtl/lmss_sync.v ====
// Purpose: two-stage synchroniser for a vector of pin inputs
// Assumes: bits are independent levels
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module lmss_sync #(
    parameter W = 24
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Data
    input wire [W-1:0] din,
    output reg [W-1:0] dout
);
    reg [W-1:0] meta;

    always @(posedge aclk) begin
        if (!aresetn) begin
            meta <= {W{1'b0}};
            dout <= {W{1'b0}};
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule // lmss_sync

// ==== verif/lmss_sva.sv ====
// Purpose: temporal checks on the supervisor ports
// Assumes: pin changes reach the outputs within four edges
// Notes: bound into every lmss_top
`timescale 1ns/1ps
module lmss_sva (
    // Clock and reset
    input wire aclk, aresetn,
    // Pins
    input wire inspection_mode_input, inspection_mode_input_alt, emergency_operation_input,
    input wire light_voltage_ok, ptc_above_high, correction_switch, terminal_flush_level,
    input wire car_moving, call_end_button, ok_button,
    // Commands and status
    input wire car_calls_block, landing_calls_block, door_open_inhibit, relevel_enable,
    input wire homing_request, travel_block, terminal_overtravel_allow, speed_reduce,
    input wire terminal_stop, parking_disable, remote_report, fault_active,
    input wire runtime_blocked, overload_active
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire norm = inspection_mode_input & inspection_mode_input_alt & emergency_operation_input;
    wire eeo_only = inspection_mode_input & inspection_mode_input_alt & !norm;
    AST_INSP: assert property ((!inspection_mode_input)[*4] |=> car_calls_block
        && landing_calls_block && door_open_inhibit && !relevel_enable && !homing_request)
        else $error("inspection not blocking");
    AST_TERM: assert property ((!inspection_mode_input && terminal_flush_level)[*4]
        |=> terminal_stop) else $error("no terminal stop");
    AST_EEO: assert property ((eeo_only && correction_switch)[*4] |=> car_calls_block
        && terminal_overtravel_allow && speed_reduce) else $error("emergency mode wrong");
    AST_BOTH: assert property ((!inspection_mode_input && !emergency_operation_input)[*4]
        |=> travel_block) else $error("car free with both modes");
    AST_LAND: assert property (parking_disable[*2] |-> landing_calls_block)
        else $error("landing calls open");
    AST_LIGHT: assert property ((norm && !light_voltage_ok)[*4] |=> fault_active
        && travel_block) else $error("light failure ignored");
    AST_REPORT: assert property (remote_report |-> $past(ptc_above_high, 3))
        else $error("report without trip");
    AST_UNBLK: assert property ($fell(runtime_blocked) && $past(aresetn)
        |-> $past(ok_button, 3) && $past(call_end_button, 3)) else $error("unblock uncommanded");
    AST_OVL: assert property (car_moving[*4] |=> $stable(overload_active))
        else $error("overload sampled while moving");
    cover property (runtime_blocked);
    cover property (remote_report);
    cover property (travel_block && fault_active);
endmodule // lmss_sva
bind lmss_top lmss_sva u_sva (.*);

// ==== verif/lmss_shaft.sv ====
// Purpose: shaft pulses, car motion and operator keys
// Assumes: bench commands run, pulse_on and unblock
// Notes: switch lines keep their level when the car stalls
`timescale 1ns/1ps
module lmss_shaft (
    // Clock and commands
    input wire aclk, run, pulse_on, unblock,
    // Shaft and operator
    output logic car_moving = 1'h0,
    output logic shaft_pulse_input_a = 1'h0,
    output logic shaft_pulse_input_b = 1'h1,
    output logic encoder_point = 1'h0,
    output logic call_end_button = 1'h0,
    output logic ok_button = 1'h0
);
    logic [2:0] cnt = 3'h0;
    logic [2:0] key = 3'h0;
    always @(posedge aclk) begin
        car_moving <= run;
        cnt <= cnt + 3'h1;
        if (run && pulse_on && cnt == 3'h7) begin
            shaft_pulse_input_a <= ~shaft_pulse_input_a;
            shaft_pulse_input_b <= ~shaft_pulse_input_b;
            encoder_point <= ~encoder_point;
        end
        // Call/end first, OK later while call/end held
        key <= unblock ? key + {2'h0, key != 3'h7} : 3'h0;
        call_end_button <= key != 3'h0;
        ok_button <= key > 3'h3;
    end
endmodule // lmss_shaft

// ==== verif/lmss_tb_top.sv ====
// Purpose: self-checking bench of the supervisor
// Assumes: one second scaled to ten clocks
// Notes: mode cases from a table, monitors by hand
`timescale 1ns/1ps
module lmss_tb_top;
    logic aclk, aresetn = 1'h0, run = 1'h0, pulse_on = 1'h0, unblock = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, rv;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] rr;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic inspection_mode_input = 1'h1, inspection_mode_input_alt = 1'h1;
    logic emergency_operation_input = 1'h1, light_voltage_ok = 1'h1, ptc_below_low = 1'h1;
    logic ptc_above_high = 1'h0, top_emergency_limit = 1'h0, up_creep_fault = 1'h0;
    logic down_creep_fault = 1'h0, overload_input = 1'h0, excess_pressure_input = 1'h0;
    logic safety_circuit_closed = 1'h1, flush_level_switch = 1'h0, correction_switch = 1'h0;
    logic terminal_flush_level = 1'h0, at_bottom_landing = 1'h0, in_landing_zone = 1'h0;
    logic door_closed = 1'h1;
    wire car_moving, shaft_pulse_input_a, shaft_pulse_input_b, encoder_point;
    wire call_end_button, ok_button, s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire calls_clear, car_calls_block, landing_calls_block, door_open_inhibit, door_cycle_req;
    wire door_open_button_enable, parking_disable, speed_reduce, terminal_stop;
    wire terminal_overtravel_allow, stop_immediate, stop_next_flush, motor_switch_off;
    wire travel_block, relevel_enable, creep_enable, homing_request, cabin_light_on;
    wire fault_active, remote_report, runtime_blocked, overload_active;
    int fail_count = 0, compares = 0, i, n;
    // Pins {insp, alt, eeo, corr, term, light, bottom, zone}, expected, mask
    logic [19:0] rows [6] = '{20'he603f, 20'h6dd3d, 20'ha4c3d, 20'hdce3d, 20'h44cbf, 20'he10c3};
    lmss_top #(.TICK_CYCLES(24'ha)) i_dut (.*);
    lmss_shaft i_shaft (.*);
    task automatic chk(input string nm, input logic [31:0] s, e);
        compares++;
        if (s !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        forever begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid === 1'h1) break;
        end
        rr = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        forever begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid === 1'h1) break;
        end
        rv = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        aclk = 1'h0;
        forever #50 aclk = ~aclk;
    end
    // Whole run takes near 740 cycles
    initial begin
        #800000;
        fail_count++;
        give_verdict();
    end
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        for (i = 0; i < 6; i++) begin
            {inspection_mode_input, inspection_mode_input_alt, emergency_operation_input,
                correction_switch, terminal_flush_level, light_voltage_ok, at_bottom_landing,
                in_landing_zone} <= rows[i][19:12];
            repeat (8) @(posedge aclk);
            chk("modes", {car_calls_block, door_open_inhibit, terminal_overtravel_allow,
                terminal_stop, travel_block, fault_active} & rows[i][5:0],
                rows[i][11:6] & rows[i][5:0]);
        end
        light_voltage_ok <= 1'h1;
        $display("test modes done");
        // Reset again in mid-run
        aresetn <= 1'h0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        chk("light", cabin_light_on, 32'h1);
        rd(8'h04);
        chk("runtime", rv, 32'h2d);
        rd(8'h18);
        chk("rd unmapped", rr, 32'h2);
        wr(8'h18, 32'h1);
        chk("wr unmapped", rr, 32'h2);
        wr(8'h00, 32'h2);
        repeat (4) @(posedge aclk);
        chk("land", {parking_disable, landing_calls_block, car_calls_block}, 32'h6);
        $display("test registers done");
        wr(8'h04, 32'h3);
        for (i = 0; i < 2; i++) begin
            wr(8'h00, i ? 32'h8 : 32'h0);
            run <= 1'h1;
            pulse_on <= 1'h1;
            repeat (200) @(posedge aclk);
            chk("pulsed", runtime_blocked, 32'h0);
            pulse_on <= 1'h0;
            repeat (100) @(posedge aclk);
            chk("stalled", runtime_blocked, 32'h1);
            run <= 1'h0;
            unblock <= 1'h1;
            repeat (12) @(posedge aclk);
            unblock <= 1'h0;
            repeat (4) @(posedge aclk);
            chk("unblock", runtime_blocked, 32'h0);
        end
        $display("test runtime done");
        ptc_below_low <= 1'h0;
        ptc_above_high <= 1'h1;
        n = 0;
        while (remote_report !== 1'h1 && n < 20) begin
            @(posedge aclk);
            n++;
        end
        chk("report", n < 20, 32'h1);
        rd(8'h14);
        chk("log", rv[0], 32'h1);
        ptc_above_high <= 1'h0;
        ptc_below_low <= 1'h1;
        wr(8'h00, 32'h1);
        overload_input <= 1'h1;
        down_creep_fault <= 1'h1;
        excess_pressure_input <= 1'h1;
        repeat (8) @(posedge aclk);
        chk("hydraulic", {overload_active, stop_immediate, creep_enable}, 32'h7);
        $display("test monitors done");
        give_verdict();
    end
endmodule // lmss_tb_top
